// [hw/lrcss_dev.sv]
`timescale 1ns/1ps
module lrcss_dev #(
    parameter int NUM_CHANNELS = lrcss_pkg::NUM_CH,
    parameter int LOSS_LIMIT   = lrcss_pkg::LOSS_CYCLES
) (
    input  wire logic                                       clock,
    input  wire logic                                       rst_n,
    input  wire logic                                       clk_en,
    input  wire logic [NUM_CHANNELS*lrcss_pkg::RATE_W-1:0] channel_rate,
    output logic                                            sfm_active,
    output logic                                            mode_valid,
    output logic [lrcss_pkg::NUM_SRC-1:0]                  source_alive,
    lrcss_if.dev                                            pins
);
    import lrcss_pkg::*;

    // Start-up sequence: wait for the strap to settle, then run
    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b10
    } lrcss_dev_state_t;

    localparam int SETTLE_W  = $clog2(STRAP_SETTLE + 1);
    localparam int SILENCE_W = $clog2(LOSS_LIMIT + 1);
    localparam logic [SETTLE_W-1:0]  SETTLE_END = SETTLE_W'(STRAP_SETTLE);
    localparam logic [SILENCE_W-1:0] SILENCE_MAX = SILENCE_W'(LOSS_LIMIT);

    // Map a rate code to its source index; reserved code falls to DS3
    function automatic logic [1:0] src_of(input logic [RATE_W-1:0] code);
        case (code)
            RATE_E3:   src_of = 2'(SRC_E3);
            RATE_DS3:  src_of = 2'(SRC_DS3);
            RATE_STS1: src_of = 2'(SRC_STS1);
            default:   src_of = 2'(SRC_DS3);
        endcase
    endfunction : src_of

    // Raw pin vector: strap on top, rate pins below
    wire  [NUM_SRC:0]          pin_raw;
    logic [NUM_SRC:0]          meta_reg;             // First sync stage
    logic [NUM_SRC:0]          sync_reg;             // Second sync stage
    logic [NUM_SRC:0]          prev_reg;             // Delayed copy for edges
    wire  [NUM_SRC:0]          pin_rise;             // Rising edge per pin

    lrcss_dev_state_t          state_reg;            // Start-up state
    lrcss_dev_state_t          state_next;
    logic [SETTLE_W-1:0]       settle_reg;           // Strap settle count
    logic [SETTLE_W-1:0]       settle_next;
    logic                      sfm_reg;              // Captured mode
    logic                      sfm_next;
    logic                      valid_reg;            // Mode captured flag
    wire                       running;              // In run state

    logic [ACC_W-1:0]          acc_reg [NUM_SRC];    // Phase per rate
    wire  [NUM_SRC-1:0]        rate_clk;             // Rate clocks, scaled
    logic [SILENCE_W-1:0]      silence_reg [NUM_SRC];// Cycles since edge
    logic [NUM_SRC-1:0]        alive_reg;            // Pin activity seen
    logic [NUM_CHANNELS-1:0]   out_reg;              // Channel outputs

    assign pin_raw = {pins.single_freq_mode_enable,
                      pins.sts1_or_synth_ref_in,
                      pins.ds3_rate_ref_in,
                      pins.e3_rate_ref_in};

    // Two-stage synchroniser plus edge history for every pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else if (clk_en) begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edge detect looks only at the second stage and its copy
    assign pin_rise = sync_reg & ~prev_reg;
    assign running  = (state_reg == ST_RUN);

    // Next state: strap is sampled once after it has settled
    always_comb begin
        state_next  = state_reg;
        settle_next = settle_reg;
        sfm_next    = sfm_reg;
        case (state_reg)
            ST_CAPTURE: begin
                // Count out the synchroniser latency
                if (settle_reg == SETTLE_END) begin
                    sfm_next   = sync_reg[STRAP_IX];
                    state_next = ST_RUN;
                end else begin
                    settle_next = settle_reg + 1'b1;
                end
            end
            ST_RUN: begin
                // Mode stays fixed until the next reset
                state_next = ST_RUN;
            end
            default: begin
                // Illegal code: restart the capture
                state_next  = ST_CAPTURE;
                settle_next = '0;
            end
        endcase
    end

    // Start-up registers; mode defaults to external clocks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_CAPTURE;
            settle_reg <= '0;
            sfm_reg    <= 1'b0;
            valid_reg  <= 1'b0;
        end else if (clk_en) begin
            state_reg  <= state_next;
            settle_reg <= settle_next;
            sfm_reg    <= sfm_next;
            valid_reg  <= (state_next == ST_RUN);
        end
    end

    // One phase accumulator per line rate
    generate
        for (genvar r = 0; r < NUM_SRC; r++) begin : g_rate
            wire             step;                     // Advance this cycle
            wire [ACC_W-1:0] inc;                      // Step size
            wire [ACC_W-1:0] acc_next;                 // Advanced phase

            // Synth mode steps on reference edges, else on own pin
            assign step     = sfm_reg ? pin_rise[SRC_STS1] : pin_rise[r];
            // Synth ratio per rate, or a plain divide by four
            assign inc      = sfm_reg ? SYN_INC[r] : EXT_INC;
            assign acc_next = acc_reg[r] + inc;
            assign rate_clk[r] = acc_reg[r][ACC_W-1];

            // Phase advances only while running
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    acc_reg[r] <= '0;
                end else if (clk_en) begin
                    if (!running) begin
                        acc_reg[r] <= '0;
                    end else if (step) begin
                        acc_reg[r] <= acc_next;
                    end
                end
            end

            // Silence counter saturates when a pin stops toggling
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    silence_reg[r] <= SILENCE_MAX;
                    alive_reg[r]   <= 1'b0;
                end else if (clk_en) begin
                    if (pin_rise[r]) begin
                        silence_reg[r] <= '0;
                    end else if (silence_reg[r] != SILENCE_MAX) begin
                        silence_reg[r] <= silence_reg[r] + 1'b1;
                    end
                    alive_reg[r] <= (silence_reg[r] != SILENCE_MAX);
                end
            end
        end
    endgenerate

    // Per-channel selection of the matching rate clock
    generate
        for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
            wire [1:0] sel;                            // Source for channel
            wire       sel_clk;                        // Selected rate clock

            assign sel     = src_of(channel_rate[c*RATE_W +: RATE_W]);
            assign sel_clk = rate_clk[sel];

            // Output is held low until the mode is known
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    out_reg[c] <= 1'b0;
                end else if (clk_en) begin
                    out_reg[c] <= running & sel_clk;
                end
            end
        end
    endgenerate

    // Outputs straight from flip-flops
    assign pins.per_channel_ref_out = out_reg;
    assign sfm_active               = sfm_reg;
    assign mode_valid               = valid_reg;
    assign source_alive             = alive_reg;

endmodule : lrcss_dev

// [hw/lrcss_pkg.sv]
package lrcss_pkg;

    // Channel count and per-channel rate code width
    localparam int NUM_CH = 12;
    localparam int RATE_W = 2;

    // Per-channel line rate; code 3 is reserved and handled as DS3
    typedef enum logic [1:0] {
        RATE_E3   = 2'h0,
        RATE_DS3  = 2'h1,
        RATE_STS1 = 2'h2
    } lrcss_rate_t;

    // Rate source indexes
    localparam int NUM_SRC  = 3;
    localparam int SRC_E3   = 0;
    localparam int SRC_DS3  = 1;
    localparam int SRC_STS1 = 2;
    localparam int SRC_REF  = 3;     // Board-only 12.288 MHz oscillator
    localparam int NUM_OSC  = 4;
    localparam int STRAP_IX = 3;     // Strap bit in the device sync vector

    // Frequencies in kHz and the system clock
    localparam int F_E3_KHZ      = 34368;
    localparam int F_DS3_KHZ     = 44736;
    localparam int F_STS1_KHZ    = 51840;
    localparam int F_SFM_REF_KHZ = 12288;
    localparam int F_SYS_KHZ     = 10000;
    localparam int SYS_PERIOD_NS = 100;
    localparam int REF_PPM       = 20;

    // Model scaling: pins and outputs carry divided-down clocks
    localparam int PIN_SCALE     = 16;   // Rate pins carry f/16
    localparam int SFM_PIN_SCALE = 4;    // Synth reference pin carries f/4
    localparam int OUT_SCALE     = 64;   // Channel outputs carry f/64

    // Phase accumulator width and increments
    localparam int ACC_W   = 16;
    localparam int SYN_MUL = (2 ** ACC_W) * SFM_PIN_SCALE / OUT_SCALE;
    localparam int BRD_MUL = (2 ** ACC_W) / PIN_SCALE;
    localparam int REF_MUL = (2 ** ACC_W) / SFM_PIN_SCALE;

    // External path: one add per rate pin edge, divide by four
    localparam logic [ACC_W-1:0] EXT_INC = ACC_W'((2 ** ACC_W) * PIN_SCALE / OUT_SCALE);

    // Synth path: one add per reference pin edge
    localparam logic [ACC_W-1:0] SYN_INC [NUM_SRC] = '{
        ACC_W'(F_E3_KHZ   * SYN_MUL / F_SFM_REF_KHZ),
        ACC_W'(F_DS3_KHZ  * SYN_MUL / F_SFM_REF_KHZ),
        ACC_W'(F_STS1_KHZ * SYN_MUL / F_SFM_REF_KHZ)
    };

    // Board oscillators, one add per system clock
    localparam logic [ACC_W-1:0] BRD_INC [NUM_OSC] = '{
        ACC_W'(F_E3_KHZ      * BRD_MUL / F_SYS_KHZ),
        ACC_W'(F_DS3_KHZ     * BRD_MUL / F_SYS_KHZ),
        ACC_W'(F_STS1_KHZ    * BRD_MUL / F_SYS_KHZ),
        ACC_W'(F_SFM_REF_KHZ * REF_MUL / F_SYS_KHZ)
    };

    // Strap settle time after reset release, and pin silence limit
    localparam int STRAP_SETTLE = 3;
    localparam int LOSS_CYCLES  = 64;

endpackage : lrcss_pkg

// [hw/lrcss_if.sv]
`timescale 1ns/1ps
interface lrcss_if;
    // Rate reference pins driven by the board
    logic                         e3_rate_ref_in;
    logic                         ds3_rate_ref_in;
    logic                         sts1_or_synth_ref_in;
    // Mode strap as driven by the board
    logic                         single_freq_mode_enable_out;
    logic                         single_freq_mode_enable_oe_n;
    // Resolved strap level, weak pull-down when released
    wire                          single_freq_mode_enable;
    // Per-channel reference clocks to the framers
    logic [lrcss_pkg::NUM_CH-1:0] per_channel_ref_out;

    // Released strap reads low
    assign single_freq_mode_enable = ~single_freq_mode_enable_oe_n & single_freq_mode_enable_out;

    modport dev (
        input  e3_rate_ref_in,
        input  ds3_rate_ref_in,
        input  sts1_or_synth_ref_in,
        input  single_freq_mode_enable,
        output per_channel_ref_out
    );

    modport brd (
        output e3_rate_ref_in,
        output ds3_rate_ref_in,
        output sts1_or_synth_ref_in,
        output single_freq_mode_enable_out,
        output single_freq_mode_enable_oe_n,
        input  per_channel_ref_out
    );
endinterface : lrcss_if

// [hw/lrcss_brd.sv]
`timescale 1ns/1ps
module lrcss_brd #(
    parameter int NUM_CHANNELS = lrcss_pkg::NUM_CH
) (
    input  wire logic                                       clock,
    input  wire logic                                       rst_n,
    input  wire logic                                       clk_en,
    input  wire logic                                       strap_drive,
    input  wire logic                                       strap_value,
    input  wire logic [NUM_CHANNELS*lrcss_pkg::RATE_W-1:0] channel_rate,
    output logic [NUM_CHANNELS-1:0]                         framer_ref_clk,
    lrcss_if.brd                                            pins
);
    import lrcss_pkg::*;

    logic [ACC_W-1:0]        osc_reg [NUM_OSC];      // Oscillator phases
    wire  [NUM_OSC-1:0]      osc_clk;                // Oscillator outputs
    logic                    need_e3;                // Some channel at E3
    logic                    need_ds3;               // Some channel at DS3
    logic                    need_sts1;              // Some channel at STS-1
    logic                    all_e3;                 // Every channel at E3
    logic                    all_sts1;               // Every channel at STS-1
    wire                     sfm_sel;                // Board picks synth mode
    wire                     e3_next;
    wire                     ds3_next;
    wire                     sts1_next;
    logic                    e3_reg;                 // E3 pin drive
    logic                    ds3_reg;                // DS3 pin drive
    logic                    sts1_reg;               // Shared pin drive
    logic                    strap_out_reg;          // Strap level
    logic                    strap_oe_n_reg;         // Strap enable, low drives
    logic [NUM_CHANNELS-1:0] meta_reg;               // Framer sync stage 1
    logic [NUM_CHANNELS-1:0] fr_reg;                 // Framer sync stage 2

    // Free-running oscillators from the system clock
    generate
        for (genvar i = 0; i < NUM_OSC; i++) begin : g_osc
            assign osc_clk[i] = osc_reg[i][ACC_W-1];
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    osc_reg[i] <= '0;
                end else if (clk_en) begin
                    osc_reg[i] <= osc_reg[i] + BRD_INC[i];
                end
            end
        end
    endgenerate

    // Summary of channel rates
    always_comb begin
        need_e3   = 1'b0;
        need_ds3  = 1'b0;
        need_sts1 = 1'b0;
        all_e3    = 1'b1;
        all_sts1  = 1'b1;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            // Reserved code counts as DS3, as the device reads it
            if (channel_rate[c*RATE_W +: RATE_W] == RATE_E3) begin
                need_e3 = 1'b1;
            end else if (channel_rate[c*RATE_W +: RATE_W] == RATE_STS1) begin
                need_sts1 = 1'b1;
            end else begin
                need_ds3 = 1'b1;
            end
            if (channel_rate[c*RATE_W +: RATE_W] != RATE_E3) begin
                all_e3 = 1'b0;
            end
            if (channel_rate[c*RATE_W +: RATE_W] != RATE_STS1) begin
                all_sts1 = 1'b0;
            end
        end
    end

    // Released strap means external clocks
    assign sfm_sel   = strap_drive & strap_value;
    // E3 pin only when needed outside synth mode
    assign e3_next   = ~sfm_sel & need_e3 & osc_clk[SRC_E3];
    // DS3 pin always fed outside synth mode for host access
    assign ds3_next  = sfm_sel ? 1'b0 :
                       all_e3   ? osc_clk[SRC_E3] :
                       all_sts1 ? osc_clk[SRC_STS1] :
                       osc_clk[SRC_DS3];
    // Shared pin: 12.288 MHz reference or STS-1 clock
    assign sts1_next = sfm_sel ? osc_clk[SRC_REF] :
                       (need_sts1 & osc_clk[SRC_STS1]);

    // Registered pin drives and framer clock synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            e3_reg         <= 1'b0;
            ds3_reg        <= 1'b0;
            sts1_reg       <= 1'b0;
            strap_out_reg  <= 1'b0;
            strap_oe_n_reg <= 1'b1;
            meta_reg       <= '0;
            fr_reg         <= '0;
        end else if (clk_en) begin
            e3_reg         <= e3_next;
            ds3_reg        <= ds3_next;
            sts1_reg       <= sts1_next;
            strap_out_reg  <= strap_value;
            strap_oe_n_reg <= ~strap_drive;
            meta_reg       <= pins.per_channel_ref_out;
            fr_reg         <= meta_reg;
        end
    end

    assign pins.e3_rate_ref_in              = e3_reg;
    assign pins.ds3_rate_ref_in             = ds3_reg;
    assign pins.sts1_or_synth_ref_in        = sts1_reg;
    assign pins.single_freq_mode_enable_out = strap_out_reg;
    assign pins.single_freq_mode_enable_oe_n = strap_oe_n_reg;
    assign framer_ref_clk                   = fr_reg;

endmodule : lrcss_brd

// [dv/lrcss_assertions.sv]
`timescale 1ns/1ps
module lrcss_assertions (
    input wire logic                         clock,
    input wire logic                         rst_n,
    input wire logic                         clk_en,
    input wire logic                         e3_rate_ref_in,
    input wire logic                         ds3_rate_ref_in,
    input wire logic                         sts1_or_synth_ref_in,
    input wire logic                         single_freq_mode_enable_out,
    input wire logic                         single_freq_mode_enable_oe_n,
    input wire logic                         single_freq_mode_enable,
    input wire logic [lrcss_pkg::NUM_CH-1:0] per_channel_ref_out
);
    import lrcss_pkg::*;

    // One clock domain, quiet in reset or freeze
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n || !clk_en);

    // Rising edge of a clock-like line
    sequence s_rise(sig);
        $rose(sig);
    endsequence

    // High phase of four to thirty clocks
    sequence s_high_phase(sig);
        $stable(sig) [*3] ##[1:27] $fell(sig);
    endsequence

    // Channel clock keeps a bounded high phase
    property p_half(sig);
        s_rise(sig) |=> s_high_phase(sig);
    endproperty

    // Scaled pin clock keeps rising every few clocks
    property p_pin(sig);
        s_rise(sig) |-> ##[2:8] s_rise(sig);
    endproperty

    a_strap_resolve: assert property (
        single_freq_mode_enable == (!single_freq_mode_enable_oe_n && single_freq_mode_enable_out))
        else $error("strap level differs from its drive");
    a_synth_pins_idle: assert property (
        single_freq_mode_enable [*3] |-> !e3_rate_ref_in && !ds3_rate_ref_in)
        else $error("dedicated rate pin active in synth mode");
    a_quiet_at_start: assert property (
        $rose(rst_n) |-> (per_channel_ref_out == '0) [*3])
        else $error("channel clock before mode capture");
    a_first_ch_half: assert property (p_half(per_channel_ref_out[0]))
        else $error("channel 0 clock phase out of range");
    a_last_ch_half: assert property (p_half(per_channel_ref_out[NUM_CH-1]))
        else $error("last channel clock phase out of range");
    a_e3_pin_runs: assert property (p_pin(e3_rate_ref_in))
        else $error("e3 pin clock stalled");
    a_ds3_pin_runs: assert property (p_pin(ds3_rate_ref_in))
        else $error("ds3 pin clock stalled");
    a_shared_pin_runs: assert property (p_pin(sts1_or_synth_ref_in))
        else $error("shared pin clock stalled");
endmodule : lrcss_assertions

// [dv/lrcss_tb_top.sv]
`timescale 1ns/1ps
module lrcss_tb_top;
    import lrcss_pkg::*;

    localparam int          LOSS = 16;          // Short silence limit
    localparam int          NWIN = 2000;        // Rate window in clocks
    localparam logic [23:0] MIX  = 24'hE4E4E4;  // Codes 0..3 repeating

    logic                     clock;        // System clock
    logic                     rst_n;        // Shared reset
    logic                     clk_en;       // Run enable
    logic                     strap_drive;  // Board drives the strap
    logic                     strap_value;  // Driven strap level
    logic [NUM_CH*RATE_W-1:0] rates;        // Rate codes, main pair
    logic                     sfm_active;   // Main device mode
    logic                     mode_valid;   // Main device captured
    logic [NUM_SRC-1:0]       alive;        // Main pin activity
    logic [NUM_CH-1:0]        framer;       // Board channel clocks
    logic                     sfm2;         // Faulted device mode
    logic                     valid2;       // Faulted device captured
    logic [NUM_SRC-1:0]       alive2;       // Faulted pin activity
    int                       error_cnt;    // Mismatches
    int                       n_compared;   // Comparisons

    lrcss_if i_lrcss_if ();      // Device facing board
    lrcss_if i_lrcss_if_flt ();  // Device facing a faulty driver
    wire e3_pin  = i_lrcss_if.e3_rate_ref_in;
    wire ds3_pin = i_lrcss_if.ds3_rate_ref_in;
    wire sh_pin  = i_lrcss_if.sts1_or_synth_ref_in;

    lrcss_dev #(.LOSS_LIMIT(LOSS)) i_lrcss_dev (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .channel_rate(rates),
        .sfm_active(sfm_active), .mode_valid(mode_valid), .source_alive(alive),
        .pins(i_lrcss_if.dev));
    lrcss_brd i_lrcss_brd (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .strap_drive(strap_drive),
        .strap_value(strap_value), .channel_rate(rates), .framer_ref_clk(framer),
        .pins(i_lrcss_if.brd));
    // Channel 1 at DS3, the rest at E3
    lrcss_dev #(.LOSS_LIMIT(LOSS)) i_lrcss_dev_flt (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .channel_rate(24'h000004),
        .sfm_active(sfm2), .mode_valid(valid2), .source_alive(alive2),
        .pins(i_lrcss_if_flt.dev));
    lrcss_assertions i_lrcss_assertions (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .e3_rate_ref_in(e3_pin),
        .ds3_rate_ref_in(ds3_pin), .sts1_or_synth_ref_in(sh_pin),
        .single_freq_mode_enable_out(i_lrcss_if.single_freq_mode_enable_out),
        .single_freq_mode_enable_oe_n(i_lrcss_if.single_freq_mode_enable_oe_n),
        .single_freq_mode_enable(i_lrcss_if.single_freq_mode_enable),
        .per_channel_ref_out(i_lrcss_if.per_channel_ref_out));

    // Clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Advance n edges, land just after the last
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock);
            #10;
        end
    endtask : step

    // Exact compare of design values
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // Count compare with tolerance
    task automatic chk_near(input string nm, input int exp, input int got, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            error_cnt++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_near

    // Expected rising edges of a scaled clock
    function automatic int exp_rises(input int khz, input int cyc, input int scale);
        return khz * cyc / (scale * F_SYS_KHZ);
    endfunction : exp_rises

    // Reset with a strap setting, then wait for the capture
    task automatic restart(input logic drv, input logic val, input logic [23:0] r);
        int k;
        rst_n = 1'b0;
        clk_en = 1'b1;
        strap_drive = drv;
        strap_value = val;
        rates = r;
        step(3);
        rst_n = 1'b1;
        k = 0;
        while (mode_valid !== 1'b1 && k < 20) begin
            step(1);
            k++;
        end
        chk_near("capture_edge", STRAP_SETTLE + 1, k, 0);
        chk("mode_valid", 12'h1, 12'(mode_valid));
    endtask : restart

    // Channels 0..3 carry codes 0..3, code 3 runs as DS3
    task automatic check_rates();
        int cnt[4] = '{default: 0};
        int f[4] = '{F_E3_KHZ, F_DS3_KHZ, F_STS1_KHZ, F_DS3_KHZ};
        logic [3:0] prev;
        step(100);
        prev = framer[3:0];
        repeat (NWIN) begin
            step(1);
            for (int c = 0; c < 4; c++) if (framer[c] && !prev[c]) cnt[c]++;
            prev = framer[3:0];
        end
        for (int c = 0; c < 4; c++) begin
            chk_near("channel_rises", exp_rises(f[c], NWIN, OUT_SCALE), cnt[c], 2);
        end
    endtask : check_rates

    // DS3 pin copies the used rate pin
    task automatic check_follow(input logic sts1, input int khz);
        int bad = 0;
        int idle = 0;
        int rises = 0;
        logic src;
        logic prev;
        step(20);
        prev = sts1 ? sh_pin : e3_pin;
        repeat (400) begin
            step(1);
            src = sts1 ? sh_pin : e3_pin;
            if (ds3_pin !== src) bad++;
            if ((sts1 ? e3_pin : sh_pin) !== 1'b0) idle++;
            if (src && !prev) rises++;
            prev = src;
        end
        chk_near("ds3_pin_copy", 0, bad, 0);
        chk_near("unused_pin_high", 0, idle, 0);
        chk_near("pin_rises", exp_rises(khz, 400, PIN_SCALE), rises, 2);
    endtask : check_follow

    // External mixed rates
    task automatic test_ext_mixed();
        restart(1'b1, 1'b0, MIX);
        chk("sfm_active", 12'h0, 12'(sfm_active));
        check_rates();
        chk("source_alive", 12'h7, 12'(alive));
        $display("test_ext_mixed done");
    endtask : test_ext_mixed

    // Every channel at E3
    task automatic test_all_e3();
        restart(1'b1, 1'b0, 24'h000000);
        check_follow(1'b0, F_E3_KHZ);
        $display("test_all_e3 done");
    endtask : test_all_e3

    // Every channel at STS-1
    task automatic test_all_sts1();
        restart(1'b1, 1'b0, 24'hAAAAAA);
        check_follow(1'b1, F_STS1_KHZ);
        $display("test_all_sts1 done");
    endtask : test_all_sts1

    // Synthesizer from the shared reference
    task automatic test_synth();
        restart(1'b1, 1'b1, MIX);
        chk("sfm_active", 12'h1, 12'(sfm_active));
        check_rates();
        chk("source_alive", 12'h4, 12'(alive));
        $display("test_synth done");
    endtask : test_synth

    // Released straps; faulty driver feeds only an E3 clock
    task automatic test_fault_end();
        int k = 0;
        int r0 = 0;
        int r1 = 0;
        logic [1:0] prev;
        restart(1'b0, 1'b1, MIX);
        chk("sfm_active", 12'h0, 12'(sfm_active));
        chk("sfm_flt", 12'h0, 12'(sfm2));
        chk("valid_flt", 12'h1, 12'(valid2));
        repeat (300) begin
            prev = i_lrcss_if_flt.per_channel_ref_out[1:0];
            step(1);
            i_lrcss_if_flt.e3_rate_ref_in = k[1];
            k++;
            if (k > 44 && i_lrcss_if_flt.per_channel_ref_out[0] && !prev[0]) r0++;
            if (k > 44 && i_lrcss_if_flt.per_channel_ref_out[1] && !prev[1]) r1++;
        end
        chk_near("flt_e3_rises", 256 * PIN_SCALE / (4 * OUT_SCALE), r0, 2);
        chk_near("flt_ds3_rises", 0, r1, 0);
        chk("alive_flt", 12'h1, 12'(alive2));
        $display("test_fault_end done");
    endtask : test_fault_end

    // Strap change after capture is ignored; clk_en freezes
    task automatic test_strap_static();
        logic [NUM_CH-1:0] held;
        restart(1'b1, 1'b0, MIX);
        step(20);
        i_lrcss_if_flt.single_freq_mode_enable_oe_n = 1'b0;
        step(5);
        chk("sfm_flt_late", 12'h0, 12'(sfm2));
        clk_en = 1'b0;
        step(1);
        held = framer;
        step(20);
        chk("framer_frozen", held, framer);
        $display("test_strap_static done");
    endtask : test_strap_static

    // Verdict and end of run
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        error_cnt = 0;
        n_compared = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        strap_drive = 1'b1;
        strap_value = 1'b0;
        rates = MIX;
        i_lrcss_if_flt.e3_rate_ref_in = 1'b0;
        i_lrcss_if_flt.ds3_rate_ref_in = 1'b0;
        i_lrcss_if_flt.sts1_or_synth_ref_in = 1'b0;
        i_lrcss_if_flt.single_freq_mode_enable_out = 1'b1;
        i_lrcss_if_flt.single_freq_mode_enable_oe_n = 1'b1;
        test_ext_mixed();
        test_all_e3();
        test_all_sts1();
        test_synth();
        test_fault_end();
        test_strap_static();
        finish_test();
    end

    // Hang guard
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        $display("watchdog expired");
        finish_test();
    end
endmodule : lrcss_tb_top
